// [logic/rcsr_pkg.sv]
// Operation
// (RL1) A watchdog reset sets cause flag bit 2, and 0 there means no watchdog reset occurred.
// (RL2) Each cause flag stays set until software writes 1 to it, and writing 0 leaves it alone.
// (RL3) A reset from the external reset pin sets cause flag bit 1.
// (RL4) A power-on reset or the software whole-chip reset sets cause flag bit 0.
// (RL5) While software holds control bit 3 at 1 the external bus interface stays in reset.
// (RL6) While software holds control bit 2 at 1 the peripheral DMA stays in reset.
// (RL7) Writing 1 to control bit 1 resets only core and flash controller and self-clears in 2 cycles.
// (RL8) Writing 1 to control bit 0 resets core and all peripherals and self-clears in 2 cycles.
// (RL9) The whole-chip software reset acts as a power-on reset, including a flash settings reload.
// (RL10) Software unlocks protection with the byte sequence 59h, 16h, 88h before protected writes.
// (RL11) Bit 3 exists only on the 64-pin low-density part; bits 3 and 2 are protected on low density. The code ties bit 3 to PKG_64PIN alone.
// (RL12) Bits 31 to 4 of the control register read as 0 and ignore writes.
// (RL13) The core-only one-shot reset sets cause flag bit 7.
// (RL14) A core system reset request sets cause flag bit 5.
// (RL15) While protection is enabled, writes to the protected control bits are ignored.
// (RL16) The one-shot resets do not clear the cause flags.
package rcsr_pkg;
  localparam logic [7:0] CAUSE_OFS = 8'h04;
  localparam logic [7:0] CTRL_OFS = 8'h08;
  localparam logic [7:0] MASK_OFS = 8'h18;
  localparam int POR_BIT = 0;
  localparam int PIN_BIT = 1;
  localparam int WDT_BIT = 2;
  localparam int SYSREQ_BIT = 5;
  localparam int CORE_BIT = 7;
  localparam int CHIP_CTL_BIT = 0;
  localparam int CORE_CTL_BIT = 1;
  localparam int DMA_CTL_BIT = 2;
  localparam int BUSIF_CTL_BIT = 3;
  localparam logic [7:0] CAUSE_IMPL = 8'hA7;
  localparam logic [7:0] CAUSE_RST = 8'h01;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [1:0] ONESHOT_CYC = 2'h2;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HRESP_OKAY = 2'h0;
endpackage : rcsr_pkg

// [logic/rcsr_sync.sv]
`timescale 1ns/1ps
// Two-stage synchroniser; only the second stage leaves the module.
module rcsr_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else if (ce) begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : rcsr_sync

// [logic/rcsr_oneshot.sv]
`timescale 1ns/1ps
// Holds its output high for a fixed number of enabled cycles after a start.
module rcsr_oneshot (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic start,
  output logic pulse_r
);
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;

  assign cnt_nxt = (start && cnt_r == 2'h0) ? rcsr_pkg::ONESHOT_CYC :
                   (cnt_r != 2'h0) ? cnt_r - 2'h1 : 2'h0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 2'h0;
      pulse_r <= 1'b0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
      pulse_r <= (cnt_nxt != 2'h0);
    end
  end
endmodule : rcsr_oneshot

// [logic/rcsr_top.sv]
`timescale 1ns/1ps
module rcsr_top #(
  parameter bit LOW_DENSITY = 1'b1,
  parameter bit PKG_64PIN = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [1:0] hresp,
  output logic [31:0] hrdata,
  input wire logic por_evt,
  input wire logic pin_evt,
  input wire logic wdt_evt,
  input wire logic sysreq_evt,
  input wire logic prot_unlocked,
  output logic core_rst,
  output logic chip_rst,
  output logic bus_if_rst,
  output logic dma_rst,
  output logic irq
);
  logic ap_wr_r;
  logic [7:0] ap_addr_r;
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic [7:0] mask_r;
  logic [4:0] evt_prev_r;
  logic [4:0] evt_s;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // Event and unlock inputs arrive from other reset logic and are synchronised.
  rcsr_sync #(.W(5)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .d({prot_unlocked, sysreq_evt, wdt_evt, pin_evt, por_evt}),
    .q(evt_s)
  );

  wire [3:0] evt_rise = evt_s[3:0] & ~evt_prev_r[3:0];
  wire unlocked = evt_s[4];
  wire ap_take = ce && hsel && hready && htrans == rcsr_pkg::HTRANS_NONSEQ;
  wire [7:0] ap_addr = haddr[7:0];
  wire wr_cause = ap_wr_r && hit(ap_addr_r, rcsr_pkg::CAUSE_OFS);
  wire wr_ctrl = ap_wr_r && hit(ap_addr_r, rcsr_pkg::CTRL_OFS);
  wire wr_mask = ap_wr_r && hit(ap_addr_r, rcsr_pkg::MASK_OFS);
  wire rd_take = ap_take && !hwrite;
  wire rd_ctrl = rd_take && hit(ap_addr, rcsr_pkg::CTRL_OFS);

  // Protected writes need the unlock; bits 3 and 2 only on low density parts.
  wire prot_ok = wr_ctrl && unlocked; // [RL15] [RL10]
  wire lvl_ok = wr_ctrl && (unlocked || !LOW_DENSITY); // [RL11]
  wire chip_start = prot_ok && hwdata[rcsr_pkg::CHIP_CTL_BIT]; // [RL8]
  wire core_start = prot_ok && hwdata[rcsr_pkg::CORE_CTL_BIT]; // [RL7]

  wire bus_if_nxt = !PKG_64PIN ? 1'b0 :
                    lvl_ok ? hwdata[rcsr_pkg::BUSIF_CTL_BIT] : bus_if_rst; // [RL5] [RL11]
  wire dma_nxt = lvl_ok ? hwdata[rcsr_pkg::DMA_CTL_BIT] : dma_rst; // [RL6]

  logic [7:0] flag_set;
  always_comb begin
    flag_set = 8'h00;
    flag_set[rcsr_pkg::POR_BIT] = evt_rise[0] || chip_start; // [RL4] [RL9]
    flag_set[rcsr_pkg::PIN_BIT] = evt_rise[1]; // [RL3]
    flag_set[rcsr_pkg::WDT_BIT] = evt_rise[2]; // [RL1]
    flag_set[rcsr_pkg::SYSREQ_BIT] = evt_rise[3]; // [RL14]
    flag_set[rcsr_pkg::CORE_BIT] = core_start; // [RL13]
  end

  // Set wins over a write-one clear in the same cycle.
  wire [7:0] flag_clr = wr_cause ? hwdata[7:0] : 8'h00;
  assign flags_nxt = ((flags_r & ~flag_clr) | flag_set) & rcsr_pkg::CAUSE_IMPL; // [RL2]
  wire [7:0] mask_nxt = wr_mask ? (hwdata[7:0] & rcsr_pkg::CAUSE_IMPL) : mask_r;

  wire [3:0] ctrl_view = {bus_if_rst, dma_rst, core_rst, chip_rst};
  wire [31:0] rd_mux = hit(ap_addr, rcsr_pkg::CAUSE_OFS) ? {24'h000000, flags_r} :
                       hit(ap_addr, rcsr_pkg::CTRL_OFS) ? {28'h0000000, ctrl_view} : // [RL12]
                       hit(ap_addr, rcsr_pkg::MASK_OFS) ? {24'h000000, mask_r} :
                       32'h00000000;

  rcsr_oneshot u_core_shot (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .start(core_start),
    .pulse_r(core_rst)
  );

  rcsr_oneshot u_chip_shot (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .start(chip_start),
    .pulse_r(chip_rst)
  );

  // Bus handshake registers follow the clock enable so a frozen block stalls the bus.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp <= rcsr_pkg::HRESP_OKAY;
    end else begin
      hreadyout <= ce;
      hresp <= rcsr_pkg::HRESP_OKAY;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ap_wr_r <= 1'b0;
      ap_addr_r <= 8'h00;
      hrdata <= 32'h00000000;
    end else if (ce) begin
      ap_wr_r <= ap_take && hwrite;
      ap_addr_r <= ap_addr;
      hrdata <= rd_take ? rd_mux : 32'h00000000;
    end
  end

  // Cause flags reload CAUSE_RST only on the block's own power-on reset, never on one-shots.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= rcsr_pkg::CAUSE_RST; // [RL16]
      mask_r <= rcsr_pkg::MASK_RST;
      evt_prev_r <= 5'h00;
      bus_if_rst <= rcsr_pkg::CTRL_RST[rcsr_pkg::BUSIF_CTL_BIT];
      dma_rst <= rcsr_pkg::CTRL_RST[rcsr_pkg::DMA_CTL_BIT];
      irq <= 1'b0;
    end else if (ce) begin
      flags_r <= flags_nxt;
      mask_r <= mask_nxt;
      evt_prev_r <= evt_s;
      bus_if_rst <= bus_if_nxt;
      dma_rst <= dma_nxt;
      irq <= |(flags_nxt & mask_nxt);
    end
  end

  wdt_flag_set_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL1]
    ce && evt_rise[2] |=> flags_r[rcsr_pkg::WDT_BIT])
    else $error("Watchdog cause flag not set.");

  pin_flag_set_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL3]
    ce && evt_rise[1] |=> flags_r[rcsr_pkg::PIN_BIT])
    else $error("Pin cause flag not set.");

  por_flag_set_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL4] [RL9]
    ce && (evt_rise[0] || chip_start) |=> flags_r[rcsr_pkg::POR_BIT])
    else $error("Power-on cause flag not set.");

  chip_start_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL8]
    ce && chip_start && !chip_rst |=> chip_rst)
    else $error("Chip one-shot did not start.");

  flag_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL2]
    ce && flags_r[rcsr_pkg::WDT_BIT] && !(wr_cause && hwdata[rcsr_pkg::WDT_BIT])
    |=> flags_r[rcsr_pkg::WDT_BIT])
    else $error("Cause flag lost without a write of one.");

  flag_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL2]
    ce && wr_cause && hwdata[rcsr_pkg::PIN_BIT] && !evt_rise[1] |=> !flags_r[rcsr_pkg::PIN_BIT])
    else $error("Cause flag not cleared by write of one.");

  busif_follow_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL5]
    ce && lvl_ok && PKG_64PIN |=> bus_if_rst == $past(hwdata[rcsr_pkg::BUSIF_CTL_BIT]))
    else $error("Bus interface reset does not follow control.");

  dma_follow_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL6]
    ce && lvl_ok |=> dma_rst == $past(hwdata[rcsr_pkg::DMA_CTL_BIT]))
    else $error("DMA reset does not follow control.");

  core_len_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL7]
    ce && $rose(core_rst) ##1 ce |=> !core_rst)
    else $error("Core one-shot not two cycles.");

  chip_len_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL8]
    $rose(chip_rst) |=> chip_rst)
    else $error("Chip one-shot shorter than two cycles.");

  core_min_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL7]
    $rose(core_rst) |=> core_rst)
    else $error("Core one-shot shorter than two cycles.");

  chip_end_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL8]
    ce && $rose(chip_rst) ##1 ce |=> !chip_rst)
    else $error("Chip one-shot longer than two cycles.");

  protect_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL15]
    ce && wr_ctrl && !unlocked && !core_rst && !chip_rst |=> !core_rst && !chip_rst)
    else $error("Locked write started a one-shot.");

  busif_lock_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL15] [RL11]
    ce && wr_ctrl && !unlocked && LOW_DENSITY |=> bus_if_rst == $past(bus_if_rst))
    else $error("Locked write changed the bus interface reset.");

  dma_lock_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL15] [RL11]
    ce && wr_ctrl && !unlocked && LOW_DENSITY |=> dma_rst == $past(dma_rst))
    else $error("Locked write changed the DMA reset.");

  reserved_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL12]
    rd_ctrl |=> hrdata[31:4] == 28'h0000000)
    else $error("Reserved control bits read nonzero.");

  core_flag_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL13]
    ce && core_start |=> flags_r[rcsr_pkg::CORE_BIT])
    else $error("Core one-shot did not set its flag.");

  core_start_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL7]
    ce && core_start && !core_rst |=> core_rst)
    else $error("Core one-shot did not start.");

  sysreq_flag_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL14]
    ce && evt_rise[3] |=> flags_r[rcsr_pkg::SYSREQ_BIT])
    else $error("System request flag not set.");

  shot_keep_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL16]
    ce && (chip_rst || core_rst) && !wr_cause |=> (flags_r & $past(flags_r)) == $past(flags_r))
    else $error("One-shot reset cleared a cause flag.");

  wdt_quiet_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL1]
    ce && !evt_rise[2] && !flags_r[rcsr_pkg::WDT_BIT] |=> !flags_r[rcsr_pkg::WDT_BIT])
    else $error("Watchdog cause flag set without an event.");

  pin_quiet_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL3]
    ce && !evt_rise[1] && !flags_r[rcsr_pkg::PIN_BIT] |=> !flags_r[rcsr_pkg::PIN_BIT])
    else $error("Pin cause flag set without an event.");

  sysreq_quiet_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL14]
    ce && !evt_rise[3] && !flags_r[rcsr_pkg::SYSREQ_BIT] |=> !flags_r[rcsr_pkg::SYSREQ_BIT])
    else $error("System request flag set without an event.");

  core_quiet_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL13]
    ce && !core_start && !flags_r[rcsr_pkg::CORE_BIT] |=> !flags_r[rcsr_pkg::CORE_BIT])
    else $error("Core cause flag set without a one-shot.");

  busif_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL5]
    !(ce && lvl_ok) |=> $stable(bus_if_rst))
    else $error("Bus interface reset moved without a write.");

  dma_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL6]
    !(ce && lvl_ok) |=> $stable(dma_rst))
    else $error("DMA reset moved without a write.");

  irq_level_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL2]
    irq == |(flags_r & mask_r))
    else $error("Interrupt level does not match masked flags.");

  freeze_flags_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL2]
    !ce |=> $stable(flags_r) && $stable(mask_r))
    else $error("Flags changed while the clock enable was low.");

  freeze_ctrl_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL5] [RL6]
    !ce |=> $stable(ctrl_view))
    else $error("Reset controls changed while the clock enable was low.");

  // Every implemented cause bit is sticky until a one is written; the rest stay zero.
  generate
    for (genvar b = 0; b < 8; b++) begin : g_flag_chk
      if (rcsr_pkg::CAUSE_IMPL[b]) begin : g_impl
        flag_keep_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL2] [RL16]
          ce && flags_r[b] && !(wr_cause && hwdata[b]) |=> flags_r[b])
          else $error("Cause flag dropped without a write of one.");

        flag_wclr_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL2]
          ce && wr_cause && hwdata[b] && !flag_set[b] |=> !flags_r[b])
          else $error("Cause flag survived a write of one.");
      end else begin : g_rsvd
        flag_rsvd_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL2]
          flags_r[b] == 1'b0)
          else $error("Unimplemented cause bit set.");
      end
    end
  endgenerate

  // Each one-shot is timed by its own run counter so its length is checked cycle by cycle.
  wire [1:0] shot_bus = {chip_rst, core_rst};
  generate
    for (genvar g = 0; g < 2; g++) begin : g_shot_chk
      logic [1:0] run_r;

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          run_r <= 2'h0;
        end else if (ce) begin
          run_r <= shot_bus[g] ? run_r + 2'h1 : 2'h0;
        end
      end

      shot_len_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL7] [RL8]
        shot_bus[g] |-> run_r < 2'h2)
        else $error("One-shot reset held beyond two cycles.");

      shot_fall_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL7] [RL8]
        $fell(shot_bus[g]) |-> run_r == 2'h2)
        else $error("One-shot reset released early.");
    end
  endgenerate
endmodule : rcsr_top

// [verification/rcsr_unlock_model.sv]
`timescale 1ns/1ps
// Protection key register beside the reset block; any wrong byte locks it again.
module rcsr_unlock_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic key_valid,
  input wire logic [7:0] key_byte,
  output logic prot_unlocked
);
  logic [1:0] step_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      step_r <= 2'h0;
      prot_unlocked <= 1'b0;
    end else if (key_valid) begin
      step_r <= (step_r == 2'h0 && key_byte == 8'h59) ? 2'h1 :
        (step_r == 2'h1 && key_byte == 8'h16) ? 2'h2 : 2'h0;
      prot_unlocked <= (step_r == 2'h2 && key_byte == 8'h88);
    end
  end
endmodule : rcsr_unlock_model

// [verification/tb.sv]
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [3:0] evt = 4'h0;
  logic key_valid = 1'b0;
  logic [7:0] key_byte = 8'h0;
  logic ce = 1'b1;
  logic hreadyout, irq, prot_unlocked, core_rst, chip_rst, bus_if_rst, dma_rst;
  logic [1:0] hresp;
  logic [31:0] hrdata, rdv, d;
  int num_errors = 0;
  int num_checks = 0;
  int seed = 90;
  int cyc = 0;
  int core_cnt = 0;
  int chip_cnt = 0;
  int c0, c1;
  int bits[4] = '{rcsr_pkg::POR_BIT, rcsr_pkg::PIN_BIT, rcsr_pkg::WDT_BIT, rcsr_pkg::SYSREQ_BIT};
  always #2 clk = ~clk;
  rcsr_top uut (.clk(clk), .rst_n(rst_n), .ce(ce), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .por_evt(evt[0]),
    .pin_evt(evt[1]), .wdt_evt(evt[2]), .sysreq_evt(evt[3]), .prot_unlocked(prot_unlocked),
    .core_rst(core_rst), .chip_rst(chip_rst), .bus_if_rst(bus_if_rst), .dma_rst(dma_rst),
    .irq(irq));
  rcsr_unlock_model um (.clk(clk), .rst_n(rst_n), .key_valid(key_valid),
    .key_byte(key_byte), .prot_unlocked(prot_unlocked));
  always @(posedge clk) begin
    cyc++;
    core_cnt += (core_rst === 1'b1);
    chip_cnt += (chip_rst === 1'b1);
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  function automatic logic [31:0] flag_of(input int i);
    return 32'h1 << bits[i];
  endfunction : flag_of
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hwrite <= w;
    haddr <= {24'h0, a};
    htrans <= rcsr_pkg::HTRANS_NONSEQ;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rdv = hrdata;
    check({30'h0, hresp}, {30'h0, rcsr_pkg::HRESP_OKAY});
  endtask : bus
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic key(input logic [7:0] b);
    @(posedge clk);
    key_valid <= 1'b1;
    key_byte <= b;
    @(posedge clk);
    key_valid <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : key
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(rcsr_pkg::CAUSE_OFS);
    check(rdv, 32'h1);
    rd(rcsr_pkg::MASK_OFS);
    check(rdv, 32'h0);
    bus(1'b1, 8'h40, $random(seed));
    rd(8'h40);
    check(rdv, 32'h0);
    bus(1'b1, rcsr_pkg::CTRL_OFS, 32'hF);
    rd(rcsr_pkg::CTRL_OFS);
    check(rdv, 32'h0);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, rcsr_pkg::CAUSE_OFS, 32'hFF);
      bus(1'b1, rcsr_pkg::MASK_OFS, flag_of(i));
      evt[i] <= 1'b1;
      repeat (5) @(posedge clk);
      evt[i] <= 1'b0;
      rd(rcsr_pkg::CAUSE_OFS);
      check(rdv, flag_of(i));
      check({31'h0, irq}, 32'h1);
      bus(1'b1, rcsr_pkg::CAUSE_OFS, ~flag_of(i) & 32'hFF);
      rd(rcsr_pkg::CAUSE_OFS);
      check(rdv, flag_of(i));
      bus(1'b1, rcsr_pkg::MASK_OFS, 32'h0);
      repeat (2) @(posedge clk);
      check({31'h0, irq}, 32'h0);
      bus(1'b1, rcsr_pkg::CAUSE_OFS, flag_of(i));
      rd(rcsr_pkg::CAUSE_OFS);
      check(rdv, 32'h0);
    end
    ce <= 1'b0;
    evt[1] <= 1'b1;
    repeat (6) @(posedge clk);
    evt[1] <= 1'b0;
    check({31'h0, hreadyout}, 32'h0);
    ce <= 1'b1;
    repeat (6) @(posedge clk);
    rd(rcsr_pkg::CAUSE_OFS);
    check(rdv, 32'h0);
    key(8'h59);
    key(8'h16);
    key(8'h88);
    d = $random(seed);
    bus(1'b1, rcsr_pkg::CTRL_OFS, (d & ~32'h3) | 32'hC);
    rd(rcsr_pkg::CTRL_OFS);
    check(rdv, 32'hC);
    check({30'h0, bus_if_rst, dma_rst}, 32'h3);
    bus(1'b1, rcsr_pkg::CTRL_OFS, 32'h0);
    @(posedge clk);
    check({30'h0, bus_if_rst, dma_rst}, 32'h0);
    for (int j = 0; j < 2; j++) begin
      c0 = core_cnt;
      c1 = chip_cnt;
      bus(1'b1, rcsr_pkg::CTRL_OFS, (j == 0) ? 32'h2 : 32'h1);
      repeat (4) @(posedge clk);
      check(core_cnt - c0, (j == 0) ? 32'h2 : 32'h0);
      check(chip_cnt - c1, (j == 0) ? 32'h0 : 32'h2);
      rd(rcsr_pkg::CAUSE_OFS);
      check(rdv, (j == 0) ? 32'h80 : 32'h81);
      rd(rcsr_pkg::CTRL_OFS);
      check(rdv, 32'h0);
    end
    key(8'h00);
    c0 = core_cnt;
    bus(1'b1, rcsr_pkg::CTRL_OFS, 32'h2);
    repeat (4) @(posedge clk);
    check(core_cnt - c0, 32'h0);
    rd(rcsr_pkg::CAUSE_OFS);
    check(rdv, 32'h81);
    report_and_stop();
  end
endmodule : tb
